// ---- hw/art_pkg.sv ----
package art_pkg;

  localparam logic [7:0] ART_CTRL_ADDR        = 8'hC8;
  localparam logic [7:0] ART_RELOAD_LOW_ADDR  = 8'hCA;
  localparam logic [7:0] ART_RELOAD_HIGH_ADDR = 8'hCB;
  localparam logic [7:0] ART_COUNT_LOW_ADDR   = 8'hCC;
  localparam logic [7:0] ART_COUNT_HIGH_ADDR  = 8'hCD;

  localparam int unsigned ART_BIT_HIGH_FLAG  = 7;
  localparam int unsigned ART_BIT_LOW_FLAG   = 6;
  localparam int unsigned ART_BIT_LOW_IRQ_EN = 5;
  localparam int unsigned ART_BIT_SPLIT      = 3;
  localparam int unsigned ART_BIT_RUN        = 2;
  localparam int unsigned ART_BIT_EXT_CLK    = 0;

  localparam logic [7:0] ART_CTRL_WRITE_MASK = 8'hED;
  localparam logic [7:0] ART_CTRL_RESET      = 8'h00;
  localparam logic [7:0] ART_BYTE_RESET      = 8'h00;

  localparam int unsigned ART_SYS_DIV = 12;
  localparam int unsigned ART_EXT_DIV = 8;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       bit_wr;
    logic [2:0] bit_sel;
    logic       bit_val;
  } art_sfr_req_t;

  typedef struct packed {
    logic high_fast;
    logic low_fast;
  } art_clk_sel_t;

endpackage

// ---- hw/art_timer.sv ----
`timescale 1ns/1ps
module art_timer
  import art_pkg::*;
#(
  parameter int unsigned SYS_DIV = ART_SYS_DIV,
  parameter int unsigned PRESC_W = 4
)
(
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire art_sfr_req_t sfr_req,
  input  wire art_clk_sel_t clk_sel,
  input  wire logic         timer_irq_enable,
  input  wire logic         ext_clk_div8,
  output logic [7:0]        sfr_rdata,
  output logic              sfr_hit,
  output logic              timer_irq
);

  logic [7:0] ctrl;
  logic [7:0] count_low_byte;
  logic [7:0] count_high_byte;
  logic [7:0] reload_low_byte;
  logic [7:0] reload_high_byte;
  logic [PRESC_W-1:0] presc;
  logic       sys_div_tick;
  logic       ext_sync_1;
  logic       ext_sync_2;
  logic       ext_sync_3;
  logic       ext_tick;
  logic       split_mode_select;
  logic       run_control;
  logic       external_clock_select;
  logic       slow_tick;
  logic       low_tick;
  logic       high_tick;
  logic       low_wrap;
  logic       high_wrap;
  logic       full_wrap;
  logic       wr_ctrl;
  logic       bit_ctrl;
  logic [7:0] next_ctrl;
  logic [7:0] next_count_low;
  logic [7:0] next_count_high;
  logic       rd_mapped;
  logic       next_timer_irq;

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks.

  // The prescaler must be able to count up to SYS_DIV - 1, and a divide by one would make the slow
  // clock a copy of the fast one, which no software expects.
  if (SYS_DIV < 2 || SYS_DIV > (1 << PRESC_W)) begin : g_bad_div
    $error("art_timer: SYS_DIV does not fit the prescaler width");
  end

  // Bits 4 and 1 must stay out of the write mask, or the unused bits would no longer read zero.
  if (ART_CTRL_WRITE_MASK[4] || ART_CTRL_WRITE_MASK[1]) begin : g_bad_mask
    $error("art_timer: control write mask covers an unused bit");
  end

  assign split_mode_select     = ctrl[ART_BIT_SPLIT];
  assign run_control           = ctrl[ART_BIT_RUN];
  assign external_clock_select = ctrl[ART_BIT_EXT_CLK];

  ////////////////////////////////////////////////////////////////////////////
  // Count enables.

  // The prescaler runs freely from reset and is never cleared by the run bit, so the first tick
  // after the timer starts may come anywhere from one to SYS_DIV cycles later. Software that needs
  // an exact first period must allow for that phase; in exchange both bytes share one divider.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      presc        <= '0;
      sys_div_tick <= 1'b0;
    end else if (presc == PRESC_W'(SYS_DIV - 1)) begin
      presc        <= '0;
      sys_div_tick <= 1'b1;
    end else begin
      presc        <= presc + PRESC_W'(1);
      sys_div_tick <= 1'b0;
    end
  end

  // The third stage only feeds the edge detector, so the first stage is seen by the second alone.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ext_sync_1 <= 1'b0;
      ext_sync_2 <= 1'b0;
      ext_sync_3 <= 1'b0;
    end else begin
      ext_sync_1 <= ext_clk_div8;
      ext_sync_2 <= ext_sync_1;
      ext_sync_3 <= ext_sync_2;
    end
  end

  assign ext_tick  = ext_sync_2 & ~ext_sync_3;
  assign slow_tick = external_clock_select ? ext_tick : sys_div_tick;

  // In split mode the low byte ignores the run bit entirely, so it keeps counting while the high
  // byte is stopped. A user who wants both stopped must leave split mode first.
  always_comb begin
    if (split_mode_select) begin
      low_tick  = clk_sel.low_fast ? 1'b1 : slow_tick;
      high_tick = run_control & (clk_sel.high_fast ? 1'b1 : slow_tick);
    end else begin
      // The 16-bit counter follows the high-byte clock select.
      low_tick  = run_control & (clk_sel.high_fast ? 1'b1 : slow_tick);
      high_tick = 1'b0;
    end
  end

  assign low_wrap  = low_tick & (count_low_byte == 8'hFF);
  assign full_wrap = ~split_mode_select & low_wrap & (count_high_byte == 8'hFF);
  assign high_wrap = split_mode_select ? (high_tick & (count_high_byte == 8'hFF)) : full_wrap;

  ////////////////////////////////////////////////////////////////////////////
  // Register access.

  assign wr_ctrl  = sfr_req.wr & (sfr_req.addr == ART_CTRL_ADDR);
  assign bit_ctrl = sfr_req.bit_wr & (sfr_req.addr == ART_CTRL_ADDR);

  always_comb begin
    next_ctrl = ctrl;
    if (wr_ctrl) begin
      next_ctrl = sfr_req.wdata & ART_CTRL_WRITE_MASK;
    end else if (bit_ctrl && ART_CTRL_WRITE_MASK[sfr_req.bit_sel]) begin
      next_ctrl[sfr_req.bit_sel] = sfr_req.bit_val;
    end
    // Hardware set wins over a software clear in the same cycle.
    if (high_wrap) begin
      next_ctrl[ART_BIT_HIGH_FLAG] = 1'b1;
    end
    if (low_wrap) begin
      next_ctrl[ART_BIT_LOW_FLAG] = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl <= ART_CTRL_RESET;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reload_low_byte  <= ART_BYTE_RESET;
      reload_high_byte <= ART_BYTE_RESET;
    end else if (sfr_req.wr) begin
      if (sfr_req.addr == ART_RELOAD_LOW_ADDR) begin
        reload_low_byte <= sfr_req.wdata;
      end
      if (sfr_req.addr == ART_RELOAD_HIGH_ADDR) begin
        reload_high_byte <= sfr_req.wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counters.

  // In 16-bit mode the high byte only moves on a low-byte wrap, and a full wrap replaces both bytes
  // with the reload pair in one edge, so software never sees a half-reloaded count.
  always_comb begin
    next_count_low  = count_low_byte;
    next_count_high = count_high_byte;
    if (split_mode_select) begin
      if (low_tick) begin
        next_count_low = low_wrap ? reload_low_byte : count_low_byte + 8'h01;
      end
      if (high_tick) begin
        next_count_high = high_wrap ? reload_high_byte : count_high_byte + 8'h01;
      end
    end else if (low_tick) begin
      if (full_wrap) begin
        next_count_low  = reload_low_byte;
        next_count_high = reload_high_byte;
      end else begin
        next_count_low = count_low_byte + 8'h01;
        if (low_wrap) begin
          next_count_high = count_high_byte + 8'h01;
        end
      end
    end
    // A software write to a count byte overrides counting in that cycle.
    if (sfr_req.wr && sfr_req.addr == ART_COUNT_LOW_ADDR) begin
      next_count_low = sfr_req.wdata;
    end
    if (sfr_req.wr && sfr_req.addr == ART_COUNT_HIGH_ADDR) begin
      next_count_high = sfr_req.wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      count_low_byte  <= ART_BYTE_RESET;
      count_high_byte <= ART_BYTE_RESET;
    end else begin
      count_low_byte  <= next_count_low;
      count_high_byte <= next_count_high;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data and interrupt request.

  // Only the five timer addresses answer; every other address reads zero and raises no hit.
  always_comb begin
    case (sfr_req.addr)
      ART_CTRL_ADDR,
      ART_RELOAD_LOW_ADDR,
      ART_RELOAD_HIGH_ADDR,
      ART_COUNT_LOW_ADDR,
      ART_COUNT_HIGH_ADDR: rd_mapped = sfr_req.rd;
      default:             rd_mapped = 1'b0;
    endcase
  end

  // Read data follows the address every cycle; only the hit tells the CPU that it was asked for.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sfr_rdata <= 8'h00;
      sfr_hit   <= 1'b0;
    end else begin
      sfr_hit <= rd_mapped;
      case (sfr_req.addr)
        ART_CTRL_ADDR:        sfr_rdata <= ctrl & ART_CTRL_WRITE_MASK;
        ART_RELOAD_LOW_ADDR:  sfr_rdata <= reload_low_byte;
        ART_RELOAD_HIGH_ADDR: sfr_rdata <= reload_high_byte;
        ART_COUNT_LOW_ADDR:   sfr_rdata <= count_low_byte;
        ART_COUNT_HIGH_ADDR:  sfr_rdata <= count_high_byte;
        default:              sfr_rdata <= 8'h00;
      endcase
    end
  end

  // The request follows the flags as they will stand after this edge, so it rises on the same edge
  // as the flag that causes it. The CPU never clears the flags on vectoring, so a handler that does
  // not clear them is entered again at once.
  always_comb begin
    next_timer_irq = 1'b0;
    if (timer_irq_enable) begin
      next_timer_irq = next_ctrl[ART_BIT_HIGH_FLAG];
      if (next_ctrl[ART_BIT_LOW_IRQ_EN] && next_ctrl[ART_BIT_LOW_FLAG]) begin
        next_timer_irq = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= next_timer_irq;
    end
  end

endmodule

// ---- verification/art_timer_properties.sv ----
`timescale 1ns/1ps
module art_timer_properties
  import art_pkg::*;
(
  input wire logic         mclk,
  input wire logic         rst_n,
  input wire art_sfr_req_t sfr_req,
  input wire art_clk_sel_t clk_sel,
  input wire logic         timer_irq_enable,
  input wire logic         ext_clk_div8,
  input wire logic [7:0]   sfr_rdata,
  input wire logic         sfr_hit,
  input wire logic         timer_irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire logic rd_c = sfr_req.rd && sfr_req.addr == ART_CTRL_ADDR;
  wire logic rd_l = sfr_req.rd && sfr_req.addr == ART_RELOAD_LOW_ADDR;
  wire logic wr_l = sfr_req.wr && sfr_req.addr == ART_RELOAD_LOW_ADDR;
  ////////////////////////////////////////
  chk_ctrl_hit: assert property (rd_c |=> sfr_hit)
    else $error("no hit");
  chk_hit_pulse: assert property (!sfr_req.rd |=> !sfr_hit)
    else $error("stray hit");
  chk_unmapped_zero: assert property (sfr_req.rd && sfr_req.addr == 8'h00 |=> !sfr_hit && sfr_rdata == 8'h00)
    else $error("unmapped read");
  chk_unused_zero: assert property (rd_c |=> !sfr_rdata[4] && !sfr_rdata[1])
    else $error("unused bit set");
  chk_reload_back: assert property (wr_l ##1 !sfr_req.wr ##1 rd_l |=> sfr_rdata == $past(sfr_req.wdata, 3))
    else $error("reload lost");
  chk_irq_gate: assert property (!timer_irq_enable |=> !timer_irq)
    else $error("irq while disabled");
  // The request one edge before the read was built from the control value that the read captures.
  chk_irq_source: assert property (rd_c && timer_irq_enable && $past(timer_irq_enable) |=>
      $past(timer_irq) == (sfr_rdata[7] || sfr_rdata[5] && sfr_rdata[6]))
    else $error("irq mismatch");
  chk_flag_hold: assert property (timer_irq && timer_irq_enable && !sfr_req.wr && !sfr_req.bit_wr |=> timer_irq)
    else $error("flag dropped");
endmodule
bind art_timer art_timer_properties u_props (
  .mclk(mclk), .rst_n(rst_n), .sfr_req(sfr_req), .clk_sel(clk_sel),
  .timer_irq_enable(timer_irq_enable), .ext_clk_div8(ext_clk_div8),
  .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .timer_irq(timer_irq)
);

// ---- verification/art_ext_osc.sv ----
`timescale 1ns/1ps
module art_ext_osc #(
  parameter int HALF = 4
) (
  input  wire logic mclk,
  input  wire logic run,
  output logic      osc
);
  int cnt;
  // Idles low between bursts so the bench knows exactly how many rising edges it sent.
  always_ff @(posedge mclk) begin
    if (!run) begin
      cnt <= 0;
      osc <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      osc <= !osc;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// ---- verification/art_timer_tb.sv ----
`timescale 1ns/1ps
module art_timer_tb
  import art_pkg::*;
;
  logic         mclk = 1'b0;
  logic         rst_n = 1'b0;
  art_sfr_req_t req = '0;
  art_clk_sel_t sel = '0;
  logic         irq_en = 1'b1;
  logic         osc_run = 1'b0;
  logic         osc;
  logic [7:0]   rdata;
  logic         irq;
  int           n_errors = 0;
  int           samples_checked = 0;
  always #25 mclk = ~mclk;
  art_ext_osc u_osc (.mclk(mclk), .run(osc_run), .osc(osc));
  art_timer dut (
    .mclk(mclk), .rst_n(rst_n), .sfr_req(req), .clk_sel(sel), .timer_irq_enable(irq_en),
    .ext_clk_div8(osc), .sfr_rdata(rdata), .sfr_hit(), .timer_irq(irq)
  );
  ////////////////////////////////////////
  task automatic final_report();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic b, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk) #1;
    req = '{wr: !b, rd: 1'b0, addr: a, wdata: d, bit_wr: b, bit_sel: d[2:0], bit_val: d[7]};
    @(posedge mclk) #1;
    req = '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk) #1;
    req = '{rd: 1'b1, addr: a, default: '0};
    @(posedge mclk) #1;
    req = '0;
    chk(rdata, e);
  endtask
  task automatic wait_irq(input int lim);
    int i;
    for (i = 0; i < lim && irq !== 1'b1; i++) begin
      #50;
    end
    if (i == lim) begin
      n_errors++;
      final_report();
    end
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (6) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    rd(ART_CTRL_ADDR, ART_CTRL_RESET);
    rd(8'h00, 8'h00);
    wr(1'b0, ART_CTRL_ADDR, 8'hFF);
    rd(ART_CTRL_ADDR, ART_CTRL_WRITE_MASK);
    chk(irq, 1'b1);
    wr(1'b0, ART_CTRL_ADDR, 8'h00);
    wr(1'b1, ART_CTRL_ADDR, 8'h82);
    rd(ART_CTRL_ADDR, 8'h04);
    wr(1'b0, ART_CTRL_ADDR, 8'h00);
    wr(1'b0, ART_COUNT_LOW_ADDR, 8'h00);
    wr(1'b0, ART_CTRL_ADDR, 8'h04);
    #(50 * 118);
    wr(1'b0, ART_CTRL_ADDR, 8'h00);
    rd(ART_COUNT_LOW_ADDR, 8'(120 / ART_SYS_DIV));
    wr(1'b0, ART_COUNT_LOW_ADDR, 8'h00);
    wr(1'b0, ART_CTRL_ADDR, 8'h05);
    osc_run = 1'b1;
    #(50 * 40);
    osc_run = 1'b0;
    #(50 * 10);
    wr(1'b0, ART_CTRL_ADDR, 8'h00);
    rd(ART_COUNT_LOW_ADDR, 8'h05);
    sel.high_fast = 1'b1;
    wr(1'b0, ART_RELOAD_LOW_ADDR, 8'h34);
    rd(ART_RELOAD_LOW_ADDR, 8'h34);
    wr(1'b0, ART_RELOAD_HIGH_ADDR, 8'h12);
    wr(1'b0, ART_COUNT_LOW_ADDR, 8'hFE);
    wr(1'b0, ART_COUNT_HIGH_ADDR, 8'hFF);
    wr(1'b0, ART_CTRL_ADDR, 8'h04);
    wait_irq(20);
    rd(ART_CTRL_ADDR, 8'hC4);
    rd(ART_COUNT_HIGH_ADDR, 8'h12);
    #(50 * 20);
    rd(ART_CTRL_ADDR, 8'hC4);
    wr(1'b0, ART_CTRL_ADDR, 8'h00);
    rd(ART_CTRL_ADDR, 8'h00);
    chk(irq, 1'b0);
    sel.low_fast = 1'b1;
    wr(1'b0, ART_RELOAD_LOW_ADDR, 8'hF0);
    wr(1'b0, ART_COUNT_LOW_ADDR, 8'hFC);
    wr(1'b0, ART_COUNT_HIGH_ADDR, 8'h10);
    wr(1'b0, ART_CTRL_ADDR, 8'h08);
    #(50 * 40);
    rd(ART_COUNT_HIGH_ADDR, 8'h10);
    rd(ART_CTRL_ADDR, 8'h48);
    chk(irq, 1'b0);
    wr(1'b0, ART_CTRL_ADDR, 8'h28);
    #50;
    wait_irq(40);
    wr(1'b0, ART_RELOAD_HIGH_ADDR, 8'hF8);
    wr(1'b0, ART_CTRL_ADDR, 8'h0C);
    #(50 * 300);
    rd(ART_CTRL_ADDR, 8'hCC);
    final_report();
  end
endmodule
